// ### hdl/tmtw_timer.sv
// Behaviour
// - Set overflow flag on count overflow, and on down-count reaching capture value.
// - Hardware sets overflow flag only while both serial clock selects are zero.
// - Hardware never clears overflow flag; software writes may set or clear it.
// - External flag set by trigger falling edge or overflow, per mode bits.
// - Software clears edge-set external flag; set flag raises interrupt if enabled.
// - Receive clock select picks timer two overflow for receiver and forces baud mode.
// - Transmit clock select picks timer two overflow for transmitter and forces baud mode.
// - Trigger pin edges ignored unless external enable and not in baud mode.
// - Run control starts and stops counting; when stopped the count is kept except for enabled trigger-edge reload or capture reset.
// - In baud mode the timer advances once every two clocks.
// - Counter select picks internal ticks at speed-bit rate or count pin falling edges.
// - With either serial clock select set, always auto-reload after overflow.
// - Reload mode reloads on overflow, and on enabled trigger falling edge unless down-count enable is set.
// - Capture mode copies the count into capture register on enabled trigger edge.
// - Capture reset bit clears the count after the capture copy.
// - Timer interrupt request reaches processor only while interrupt enable is set.
//
// Added by the designer: the APB register port.
`include "tmtw_defs.svh"

module tmtw_timer
	import tmtw_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic COUNT_PIN,
	input wire logic TRIGGER_PIN,
	input wire logic TIMER_ONE_OVERFLOW,
	output logic RX_BAUD_TICK,
	output logic TX_BAUD_TICK,
	output logic TIMER_IRQ,
	output logic IRQ
);

	logic rst_meta_q, rst_sync_q;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wire logic rst_n = rst_sync_q;

	logic [7:0] control_q;
	logic [7:0] mode_q;
	logic [15:0] count_q;
	logic [15:0] capture_q;
	logic [1:0] misc_q;
	logic [2:0] irq_status_q;
	logic [2:0] irq_enable_q;
	logic count_pin_q, count_prev_q, trig_pin_q, trig_prev_q;
	logic [3:0] div_q;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
		hit = a == b;
	endfunction

	wire logic wr = PSEL && PENABLE && PWRITE;
	wire logic rclk = control_q[`TMTW_CTL_RCLK];
	wire logic tclk = control_q[`TMTW_CTL_TCLK];
	wire logic exen = control_q[`TMTW_CTL_EXEN];
	wire logic run = control_q[`TMTW_CTL_RUN];
	wire logic down_count_enable = mode_q[`TMTW_MOD_DOWN_COUNT_ENABLE];

	tmtw_mode_t mode;
	always_comb begin
		if (rclk || tclk)
			mode = TMTW_MODE_BAUD;
		else if (control_q[`TMTW_CTL_CPRL])
			mode = TMTW_MODE_CAPTURE;
		else
			mode = TMTW_MODE_RELOAD;
	end

	// Pins are registered once, then compared against the previous sample.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			count_pin_q <= 1'b1;
			count_prev_q <= 1'b1;
			trig_pin_q <= 1'b1;
			trig_prev_q <= 1'b1;
		end else begin
			count_pin_q <= COUNT_PIN;
			count_prev_q <= count_pin_q;
			trig_pin_q <= TRIGGER_PIN;
			trig_prev_q <= trig_pin_q;
		end
	end
	wire logic count_fall = count_prev_q && !count_pin_q;
	wire logic trig_fall = trig_prev_q && !trig_pin_q;
	wire logic trig_event = trig_fall && exen && mode != TMTW_MODE_BAUD;

	logic [3:0] div_limit;
	always_comb begin
		if (mode == TMTW_MODE_BAUD)
			div_limit = `TMTW_DIV_BAUD;
		else if (misc_q[`TMTW_MISC_SPEED])
			div_limit = `TMTW_DIV_FAST;
		else
			div_limit = `TMTW_DIV_SLOW;
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			div_q <= 4'h0;
		else if (!run || div_q >= div_limit - 4'h1)
			div_q <= 4'h0;
		else
			div_q <= div_q + 4'h1;
	end
	wire logic div_tick = run && div_q >= div_limit - 4'h1;

	logic tick;
	always_comb begin
		if (!run)
			tick = 1'b0;
		else if (mode == TMTW_MODE_BAUD)
			tick = div_tick;
		else if (control_q[`TMTW_CTL_CT])
			tick = count_fall;
		else
			tick = div_tick;
	end

	// Down counting only applies in reload mode with the down-count enable set.
	wire logic down = down_count_enable && mode == TMTW_MODE_RELOAD && !trig_pin_q;
	wire logic up_ovf = tick && !down && count_q == 16'hffff;
	wire logic down_ovf = tick && down && count_q == capture_q;
	wire logic ovf = up_ovf || down_ovf;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			count_q <= `TMTW_COUNT_RESET;
		else if (wr && hit(PADDR, `TMTW_ADDR_COUNT))
			count_q <= PWDATA[15:0];
		else if (trig_event && mode == TMTW_MODE_CAPTURE && mode_q[`TMTW_MOD_CRST])
			count_q <= 16'h0000;
		else if (up_ovf && mode != TMTW_MODE_CAPTURE)
			count_q <= capture_q;
		else if (down_ovf)
			count_q <= 16'hffff;
		else if (trig_event && mode == TMTW_MODE_RELOAD && !down_count_enable)
			count_q <= capture_q;
		else if (tick)
			count_q <= down ? count_q - 16'h1 : count_q + 16'h1;
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			capture_q <= 16'h0000;
		else if (trig_event && mode == TMTW_MODE_CAPTURE)
			capture_q <= count_q;
		else if (wr && hit(PADDR, `TMTW_ADDR_CAPTURE))
			capture_q <= PWDATA[15:0];
	end

	wire logic hw_ovf_set = ovf && mode != TMTW_MODE_BAUD;
	wire logic hw_exf_set = (trig_event && !(mode == TMTW_MODE_RELOAD && down_count_enable))
		|| (ovf && down_count_enable && mode == TMTW_MODE_RELOAD);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			control_q <= `TMTW_CONTROL_RESET;
		end else begin
			if (wr && hit(PADDR, `TMTW_ADDR_CONTROL))
				control_q <= PWDATA[7:0];
			if (hw_ovf_set)
				control_q[`TMTW_CTL_OVF] <= 1'b1;
			if (hw_exf_set)
				control_q[`TMTW_CTL_EXF] <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= `TMTW_MODE_RESET;
			misc_q <= 2'b00;
			irq_enable_q <= 3'b000;
		end else if (wr) begin
			if (hit(PADDR, `TMTW_ADDR_MODE))
				mode_q <= PWDATA[7:0] & `TMTW_MOD_MASK;
			if (hit(PADDR, `TMTW_ADDR_MISC))
				misc_q <= PWDATA[1:0];
			if (hit(PADDR, `TMTW_ADDR_IRQ_ENABLE))
				irq_enable_q <= PWDATA[2:0];
		end
	end

	logic [2:0] irq_set;
	assign irq_set = {trig_event && mode == TMTW_MODE_CAPTURE, hw_exf_set, hw_ovf_set};
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			irq_status_q <= 3'b000;
		else if (wr && hit(PADDR, `TMTW_ADDR_IRQ_CLEAR))
			irq_status_q <= (irq_status_q & ~PWDATA[2:0]) | irq_set;
		else
			irq_status_q <= irq_status_q | irq_set;
	end

	assign TIMER_IRQ = misc_q[`TMTW_MISC_IE]
		&& (control_q[`TMTW_CTL_OVF] || control_q[`TMTW_CTL_EXF]);
	assign IRQ = |(irq_status_q & irq_enable_q);

	// In baud mode every overflow becomes a time base tick for the serial port.
	wire logic baud_ovf = up_ovf && mode == TMTW_MODE_BAUD;
	assign RX_BAUD_TICK = rclk ? baud_ovf : TIMER_ONE_OVERFLOW;
	assign TX_BAUD_TICK = tclk ? baud_ovf : TIMER_ONE_OVERFLOW;

	logic [31:0] rdata_d;
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (PADDR)
			`TMTW_ADDR_CONTROL: rdata_d[7:0] = control_q;
			`TMTW_ADDR_MODE: rdata_d[7:0] = mode_q;
			`TMTW_ADDR_COUNT: rdata_d[15:0] = count_q;
			`TMTW_ADDR_CAPTURE: rdata_d[15:0] = capture_q;
			`TMTW_ADDR_IRQ_STATUS: rdata_d[2:0] = irq_status_q;
			`TMTW_ADDR_IRQ_ENABLE: rdata_d[2:0] = irq_enable_q;
			`TMTW_ADDR_MISC: rdata_d[1:0] = misc_q;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	function automatic logic mapped(input logic [11:0] a);
		mapped = hit(a, `TMTW_ADDR_CONTROL) || hit(a, `TMTW_ADDR_MODE) || hit(a, `TMTW_ADDR_COUNT)
			|| hit(a, `TMTW_ADDR_CAPTURE) || hit(a, `TMTW_ADDR_IRQ_STATUS)
			|| hit(a, `TMTW_ADDR_IRQ_ENABLE) || hit(a, `TMTW_ADDR_IRQ_CLEAR) || hit(a, `TMTW_ADDR_MISC);
	endfunction

	assign PRDATA = rdata_d;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);

endmodule

// ### hdl/tmtw_defs.svh
`ifndef TMTW_DEFS_SVH
`define TMTW_DEFS_SVH

// Byte addresses on the APB slave.
`define TMTW_OFF_CONTROL 12'h0c8
`define TMTW_OFF_MODE 12'h0c9
`define TMTW_IDX_CONTROL 12'h0c8
`define TMTW_IDX_MODE 12'h0c9
`define TMTW_ADDR_CONTROL 12'h320
`define TMTW_ADDR_MODE 12'h324
`define TMTW_ADDR_COUNT 12'h328
`define TMTW_ADDR_CAPTURE 12'h32c
`define TMTW_ADDR_IRQ_STATUS 12'h330
`define TMTW_ADDR_IRQ_ENABLE 12'h334
`define TMTW_ADDR_IRQ_CLEAR 12'h338
`define TMTW_ADDR_MISC 12'h33c

// Control register fields.
`define TMTW_CTL_OVF 7
`define TMTW_CTL_EXF 6
`define TMTW_CTL_RCLK 5
`define TMTW_CTL_TCLK 4
`define TMTW_CTL_EXEN 3
`define TMTW_CTL_RUN 2
`define TMTW_CTL_CT 1
`define TMTW_CTL_CPRL 0
// Mode register fields.
`define TMTW_MOD_CRST 3
`define TMTW_MOD_DOWN_COUNT_ENABLE 0
`define TMTW_MOD_MASK 8'h09
// Misc register: bit 0 timer interrupt enable, bit 1 clock speed bit.
`define TMTW_MISC_IE 0
`define TMTW_MISC_SPEED 1

`define TMTW_CONTROL_RESET 8'h00
`define TMTW_MODE_RESET 8'h00
`define TMTW_COUNT_RESET 16'h0000

// Irq status bits: 0 overflow, 1 external edge, 2 capture.
`define TMTW_IRQ_OVF 0
`define TMTW_IRQ_EDGE 1
`define TMTW_IRQ_CAP 2

// Internal tick dividers: 12 clocks (slow) or 4 clocks (fast); baud mode 2 clocks.
`define TMTW_DIV_SLOW 4'hc
`define TMTW_DIV_FAST 4'h4
`define TMTW_DIV_BAUD 4'h2

`endif

// ### hdl/tmtw_pkg.sv
package tmtw_pkg;
	typedef enum logic [1:0] {
		TMTW_MODE_RELOAD,
		TMTW_MODE_CAPTURE,
		TMTW_MODE_BAUD
	} tmtw_mode_t;
endpackage

// ### verification/tmtw_timer_properties.sv
`include "tmtw_defs.svh"
module tmtw_timer_properties(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic TIMER_ONE_OVERFLOW,
	input wire logic RX_BAUD_TICK,
	input wire logic TX_BAUD_TICK,
	input wire logic TIMER_IRQ
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] rs_q;
	logic [7:0] ctl_q;
	logic ie_q, ovf_q, wr, rd;
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && PENABLE && !PWRITE;
	// Mirrors software's view; rs_q follows the design's two-flop reset release.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rs_q <= 2'b00;
			ctl_q <= 8'h00;
			ie_q <= 1'b0;
			ovf_q <= 1'b0;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
			if (wr && PADDR == `TMTW_ADDR_CONTROL) begin
				ctl_q <= PWDATA[7:0];
				ovf_q <= 1'b0;
			end else if (rd && PADDR == `TMTW_ADDR_CONTROL && PRDATA[7]) begin
				ovf_q <= 1'b1;
			end
			if (wr && PADDR == `TMTW_ADDR_MISC) begin
				ie_q <= PWDATA[0];
			end
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rs_q[1]);
	sequence ext_wr; wr && PADDR == `TMTW_ADDR_CONTROL && PWDATA[6]; endsequence
	sequence rx_twice; ctl_q[5] && RX_BAUD_TICK ##1 ctl_q[5]; endsequence
	AST_READY: assert property (PSEL |-> PREADY)
		else $error("pready low");
	AST_RX_SRC: assert property (!ctl_q[5] |-> RX_BAUD_TICK == TIMER_ONE_OVERFLOW)
		else $error("rx source");
	AST_TX_SRC: assert property (!ctl_q[4] |-> TX_BAUD_TICK == TIMER_ONE_OVERFLOW)
		else $error("tx source");
	AST_BAUD_GAP: assert property (rx_twice |-> !RX_BAUD_TICK)
		else $error("baud gap");
	AST_OVF_STICKY: assert property (rd && PADDR == `TMTW_ADDR_CONTROL && ovf_q |-> PRDATA[7])
		else $error("flag lost");
	AST_BAUD_NO_OVF: assert property (rd && PADDR == `TMTW_ADDR_CONTROL && ctl_q[5:4] != 2'b00 && !ctl_q[7] |-> !PRDATA[7])
		else $error("flag in baud");
	AST_IE_GATE: assert property (!ie_q |-> !TIMER_IRQ)
		else $error("irq unmasked");
	AST_EXT_IRQ: assert property (ext_wr ##1 ie_q |-> TIMER_IRQ)
		else $error("no irq");
endmodule
bind tmtw_timer tmtw_timer_properties chk (.*);

// ### verification/tmtw_pins.sv
module tmtw_pins(
	input wire logic CLK,
	output logic COUNT_PIN,
	output logic TRIGGER_PIN,
	output logic TIMER_ONE_OVERFLOW
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] t1_q;
	initial begin
		t1_q = 3'h0;
		COUNT_PIN = 1'b1;
		TRIGGER_PIN = 1'b1;
		TIMER_ONE_OVERFLOW = 1'b0;
	end
	always @(posedge CLK) begin
		t1_q <= t1_q + 3'h1;
		TIMER_ONE_OVERFLOW <= t1_q == 3'h7;
	end
	// Holds the trigger pin at a level, which sets the count direction when down counting.
	task automatic level(input logic v);
		@(posedge CLK);
		TRIGGER_PIN <= v;
		repeat (3) @(posedge CLK);
	endtask
	// Each level lasts four clocks so the two-sample detector cannot miss it.
	task automatic fall(input logic on_count);
		repeat (2) begin
			@(posedge CLK);
			if (on_count) COUNT_PIN <= ~COUNT_PIN;
			else TRIGGER_PIN <= ~TRIGGER_PIN;
			repeat (3) @(posedge CLK);
		end
	endtask
endmodule

// ### verification/tb_top.sv
`include "tmtw_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] CT = `TMTW_ADDR_CONTROL, CN = `TMTW_ADDR_COUNT, CP = `TMTW_ADDR_CAPTURE;
	localparam logic [11:0] MS = `TMTW_ADDR_MISC, MD = `TMTW_ADDR_MODE;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d, e; logic s;} tmtw_row_t;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, er;
	logic rdy, slv, cp, tp, t1, rxt, txt, tirq, irq;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rd;
	int err_count = 0, samples_checked = 0, cyc = 0;
	tmtw_row_t rows[6] = '{
		'{1'b0, CT, 32'h0, `TMTW_CONTROL_RESET, 1'b0},
		'{1'b0, CN, 32'h0, `TMTW_COUNT_RESET, 1'b0},
		'{1'b1, MD, 32'hff, `TMTW_MOD_MASK, 1'b0},
		'{1'b1, CN, 32'habcd, 32'habcd, 1'b0},
		'{1'b1, `TMTW_ADDR_IRQ_STATUS, 32'h7, 32'h0, 1'b0},
		'{1'b1, 12'h340, 32'h5, 32'h0, 1'b1}
	};
	tmtw_timer dut(.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
		.PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(slv), .COUNT_PIN(cp), .TRIGGER_PIN(tp),
		.TIMER_ONE_OVERFLOW(t1), .RX_BAUD_TICK(rxt), .TX_BAUD_TICK(txt), .TIMER_IRQ(tirq), .IRQ(irq));
	tmtw_pins pins(.CLK(clk), .COUNT_PIN(cp), .TRIGGER_PIN(tp), .TIMER_ONE_OVERFLOW(t1));
	always #10 clk = ~clk;
	task automatic stop_test;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rd = prd;
		er = slv;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
			rdc(rows[i].a, 32'hffffffff, rows[i].e);
			chk(er, rows[i].s);
		end
		$display("done registers");
		apb(1'b1, MD, 32'h0);
		apb(1'b1, MS, 32'h3);
		apb(1'b1, `TMTW_ADDR_IRQ_ENABLE, 32'h1);
		apb(1'b1, CP, 32'h8000);
		apb(1'b1, CN, 32'hfffe);
		apb(1'b1, CT, 32'h04);
		wait (tirq === 1'b1);
		rdc(CT, 32'h80, 32'h80);
		rdc(CN, 32'hff00, 32'h8000);
		chk(irq, 1'b1);
		apb(1'b1, CT, 32'h0);
		#1 chk(tirq, 1'b0);
		apb(1'b1, `TMTW_ADDR_IRQ_CLEAR, 32'h7);
		#1 chk(irq, 1'b0);
		$display("done overflow");
		apb(1'b1, MS, 32'h1);
		apb(1'b1, CN, 32'h0100);
		apb(1'b1, MD, 32'h08);
		apb(1'b1, CT, 32'h0d);
		pins.fall(1'b0);
		rdc(CP, 32'hff00, 32'h0100);
		rdc(CN, 32'hff00, 32'h0);
		rdc(CT, 32'h40, 32'h40);
		apb(1'b1, CT, 32'h05);
		pins.fall(1'b0);
		rdc(CT, 32'h40, 32'h0);
		apb(1'b1, CT, 32'h40);
		#1 chk(tirq, 1'b1);
		apb(1'b1, MS, 32'h0);
		#1 chk(tirq, 1'b0);
		$display("done trigger");
		apb(1'b1, CT, 32'h0);
		apb(1'b1, CN, 32'h0);
		apb(1'b1, CT, 32'h06);
		repeat (3) pins.fall(1'b1);
		rdc(CN, 32'hffff, 32'h3);
		$display("done counter");
		apb(1'b1, CT, 32'h0);
		apb(1'b1, MD, 32'h01);
		apb(1'b1, CP, 32'h0005);
		apb(1'b1, CN, 32'h0007);
		pins.level(1'b0);
		apb(1'b1, CT, 32'h04);
		repeat (60) @(posedge clk);
		rdc(CT, 32'hc0, 32'hc0);
		rdc(CN, 32'hff00, 32'hff00);
		apb(1'b1, CT, 32'h0);
		apb(1'b1, MD, 32'h0);
		pins.level(1'b1);
		$display("done down count");
		apb(1'b1, CP, 32'hfff0);
		apb(1'b1, CN, 32'hfff0);
		apb(1'b1, CT, 32'h34);
		#1;
		wait (rxt === 1'b1);
		wait (rxt === 1'b0);
		wait (rxt === 1'b1);
		#1 chk(txt, 1'b1);
		rdc(CT, 32'h80, 32'h0);
		rdc(CN, 32'hff00, 32'hff00);
		$display("done baud");
		stop_test();
	end
endmodule
